// File: design/rvm_vector_ctrl.sv
// reset and interrupt vector map: register slave, priority, vector supply, wake and irq
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rvm_vector_ctrl
  import rvm_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // avalon-mm slave
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  // interrupt sources, bit 7 is the battery high-level flag
  input  wire logic [`RVM_NSRC-1:0] srcFlag,
  input  wire logic                battLowFlag,
  // reset causes
  input  wire logic                porReset,
  input  wire logic                lowSupplyReset,
  input  wire logic                pinReset,
  input  wire logic                illegalAddrReset,
  input  wire logic                clkMonFail,
  input  wire logic                watchdogTimeout,
  // processor core
  input  wire logic                ccrIMask,
  input  wire logic                ccrXMask,
  input  wire logic                stopMode,
  input  wire logic                waitMode,
  input  wire logic                intAck,
  input  wire logic                vecFetch,
  output logic                     coreIrq,
  output logic [15:0]              vectorAddr,
  output logic                     vectorValid,
  output logic [15:0]              resetVector,
  output logic                     resetValid,
  output logic                     wakeStop,
  output logic                     wakeWait,
  // summary interrupt
  output logic                     irqOut
);

  // registers
  logic [7:0]          vbase_q,     vbase_d;
  logic [4:0]          ctrl_q,      ctrl_d;
  logic [26:0]         enable_q,    enable_d;
  logic [2:0]          status_q,    status_d;
  logic [2:0]          mask_q,      mask_d;
  logic [31:0]         rdata_q,     rdata_d;
  logic                wait_q,      wait_d;
  rvm_fetch_type       fetch_q,     fetch_d;
  rvm_idx_type         ackIdx_q,    ackIdx_d;
  logic                ackValid_q,  ackValid_d;
  logic [15:0]         vec_q,       vec_d;
  logic                vecValid_q,  vecValid_d;
  logic [15:0]         rstVec_q,    rstVec_d;
  logic                rstValid_q,  rstValid_d;
  logic                coreIrq_q,   coreIrq_d;
  logic                wakeStop_q,  wakeStop_d;
  logic                wakeWait_q,  wakeWait_d;
  logic                irq_q,       irq_d;

  // combinational
  logic [`RVM_NSRC-1:0] gated;
  logic                 winFound;
  rvm_idx_type          winIdx;
  logic                 rstActive;
  rvm_vec_type          rstSel;
  logic                 busWrite;
  logic                 spurious;
  logic [2:0]           evSet;
  logic [2:0]           evClr;
  logic [31:0]          merged;

  // request gating by flag, local enable and I mask bit; XREQ by flag and X mask only
  always_comb begin
    gated = '0;
    for (int i = 0; i < `RVM_SRC_XREQ; i++) begin
      gated[i] = srcFlag[i] & enable_q[i] & ~ccrIMask;
    end
    gated[`RVM_SRC_BATT] = ~ccrIMask &
      ((srcFlag[`RVM_SRC_BATT] & enable_q[`RVM_SRC_BATT]) |
       (battLowFlag & ctrl_q[`RVM_CTRL_BATLO_EN]));
    gated[`RVM_SRC_XREQ] = srcFlag[`RVM_SRC_XREQ] & ~ccrXMask;
  end

  rvm_prio_enc u_prio (
    .req    (gated),
    .found  (winFound),
    .winIdx (winIdx)
  );

  rvm_reset_sel u_rst (
    .porReset         (porReset),
    .lowSupplyReset   (lowSupplyReset),
    .pinReset         (pinReset),
    .illegalAddrReset (illegalAddrReset),
    .clkMonFail       (clkMonFail),
    .watchdogTimeout  (watchdogTimeout),
    .oscEnable        (ctrl_q[`RVM_CTRL_OSC_EN]),
    .watchdogRate     (ctrl_q[`RVM_CTRL_WD_MSB:`RVM_CTRL_WD_LSB]),
    .active           (rstActive),
    .vector           (rstSel)
  );

  // bus slave: one wait cycle, write takes effect where waitrequest is low
  always_comb begin
    busWrite = write & ~wait_q;
    wait_d   = ~((read | write) & wait_q);
    rdata_d  = rdata_q;
    if (read & wait_q) begin
      unique case (address[4:2])
        `RVM_OFF_VBASE:   rdata_d = {24'h000000, vbase_q};
        `RVM_OFF_CTRL:    rdata_d = {27'h0000000, ctrl_q};
        `RVM_OFF_ENABLE:  rdata_d = {5'h00, enable_q};
        `RVM_OFF_STATUS:  rdata_d = {29'h00000000, status_q};
        `RVM_OFF_MASK:    rdata_d = {29'h00000000, mask_q};
        `RVM_OFF_PEND:    rdata_d = {4'h0, gated};
        `RVM_OFF_VECTORS: rdata_d = {rstVec_q, vec_q};
        default:          rdata_d = 32'h00000000;
      endcase
    end
  end

  // writable registers
  always_comb begin
    vbase_d  = vbase_q;
    ctrl_d   = ctrl_q;
    enable_d = enable_q;
    mask_d   = mask_q;
    evClr    = 3'h0;
    merged   = 32'h00000000;
    if (busWrite) begin
      unique case (address[4:2])
        `RVM_OFF_VBASE: begin
          merged  = laneMerge({24'h000000, vbase_q}, writedata, byteenable);
          vbase_d = merged[7:0];
        end
        `RVM_OFF_CTRL: begin
          merged = laneMerge({27'h0000000, ctrl_q}, writedata, byteenable);
          ctrl_d = merged[4:0];
        end
        `RVM_OFF_ENABLE: begin
          merged   = laneMerge({5'h00, enable_q}, writedata, byteenable);
          enable_d = merged[26:0];
        end
        `RVM_OFF_STATUS: begin
          merged = laneMerge(32'h00000000, writedata, byteenable);
          evClr  = merged[2:0];
        end
        `RVM_OFF_MASK: begin
          merged = laneMerge({29'h00000000, mask_q}, writedata, byteenable);
          mask_d = merged[2:0];
        end
        default: begin
          merged = 32'h00000000;
        end
      endcase
    end
  end

  // acknowledge and vector fetch
  always_comb begin
    fetch_d    = fetch_q;
    ackIdx_d   = ackIdx_q;
    ackValid_d = ackValid_q;
    vec_d      = vec_q;
    vecValid_d = 1'b0;
    spurious   = 1'b0;
    if (vecFetch) begin
      if (ackValid_q && gated[ackIdx_q]) begin
        vec_d = {vbase_q, srcOffset(ackIdx_q)};
      end else begin
        vec_d    = {vbase_q, `RVM_OFF_SPURIOUS};
        spurious = 1'b1;
      end
      vecValid_d = 1'b1;
      ackValid_d = 1'b0;
      fetch_d    = FETCH_IDLE;
    end else if (intAck) begin
      ackIdx_d   = winIdx;
      ackValid_d = winFound;
      fetch_d    = FETCH_ACKED;
    end
  end

  // reset vector, core request, wake and summary interrupt
  always_comb begin
    rstValid_d = rstActive;
    rstVec_d   = rstActive ? rstSel : rstVec_q;
    coreIrq_d  = |gated;
    wakeStop_d = stopMode & |(gated & `RVM_STOP_WAKE);
    wakeWait_d = waitMode & |(gated & `RVM_WAIT_WAKE);
    evSet      = {wakeStop_d | wakeWait_d, spurious, rstActive};
    status_d   = (status_q & ~evClr) | evSet;
    irq_d      = |(status_d & mask_d);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vbase_q    <= `RVM_RST_VBASE;
      ctrl_q     <= `RVM_RST_CTRL;
      enable_q   <= `RVM_RST_ENABLE;
      status_q   <= `RVM_RST_STATUS;
      mask_q     <= `RVM_RST_MASK;
      rdata_q    <= 32'h00000000;
      wait_q     <= 1'b1;
      fetch_q    <= FETCH_IDLE;
      ackIdx_q   <= 5'h00;
      ackValid_q <= 1'b0;
      vec_q      <= 16'h0000;
      vecValid_q <= 1'b0;
      rstVec_q   <= `RVM_VEC_TOP;
      rstValid_q <= 1'b0;
      coreIrq_q  <= 1'b0;
      wakeStop_q <= 1'b0;
      wakeWait_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      vbase_q    <= vbase_d;
      ctrl_q     <= ctrl_d;
      enable_q   <= enable_d;
      status_q   <= status_d;
      mask_q     <= mask_d;
      rdata_q    <= rdata_d;
      wait_q     <= wait_d;
      fetch_q    <= fetch_d;
      ackIdx_q   <= ackIdx_d;
      ackValid_q <= ackValid_d;
      vec_q      <= vec_d;
      vecValid_q <= vecValid_d;
      rstVec_q   <= rstVec_d;
      rstValid_q <= rstValid_d;
      coreIrq_q  <= coreIrq_d;
      wakeStop_q <= wakeStop_d;
      wakeWait_q <= wakeWait_d;
      irq_q      <= irq_d;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign coreIrq     = coreIrq_q;
  assign vectorAddr  = vec_q;
  assign vectorValid = vecValid_q;
  assign resetVector = rstVec_q;
  assign resetValid  = rstValid_q;
  assign wakeStop    = wakeStop_q;
  assign wakeWait    = wakeWait_q;
  assign irqOut      = irq_q;

  // checks
  logic topCause;
  assign topCause = porReset | lowSupplyReset | pinReset | illegalAddrReset;

  property p_top_reset;
    @(posedge core_clk) disable iff (!resetn)
    topCause |=> resetValid && resetVector == `RVM_VEC_TOP;
  endproperty
  a_top_reset: assert property (p_top_reset) else $error("top reset vector wrong");

  property p_clkmon_reset;
    @(posedge core_clk) disable iff (!resetn)
    (clkMonFail && !topCause) |=>
      (resetValid == $past(ctrl_q[`RVM_CTRL_OSC_EN]) || $past(watchdogTimeout))
      && (!resetValid || resetVector != `RVM_VEC_TOP);
  endproperty
  a_clkmon_reset: assert property (p_clkmon_reset) else $error("clock monitor reset gating");

  property p_wdog_reset;
    @(posedge core_clk) disable iff (!resetn)
    (watchdogTimeout && ctrl_q[3:1] != 3'h0 && !topCause && !clkMonFail)
      |=> resetValid && resetVector == `RVM_VEC_WDOG;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog reset vector wrong");

  property p_priority;
    @(posedge core_clk) disable iff (!resetn)
    (intAck && !vecFetch && gated[`RVM_SRC_XREQ]) |=> ackIdx_q == 5'd27 && ackValid_q;
  endproperty
  a_priority: assert property (p_priority) else $error("highest source not chosen");

  property p_vector_form;
    @(posedge core_clk) disable iff (!resetn)
    vecFetch |=> vectorValid && vectorAddr[15:8] == $past(vbase_q) && !vectorAddr[0];
  endproperty
  a_vector_form: assert property (p_vector_form) else $error("vector not base plus offset");

  property p_battery;
    @(posedge core_clk) disable iff (!resetn)
    (stopMode && gated == 28'h0000080) |=> !wakeStop ##0 $past(gated[`RVM_SRC_BATT]);
  endproperty
  a_battery: assert property (p_battery) else $error("battery woke from stop");

  property p_supply_oc;
    @(posedge core_clk) disable iff (!resetn)
    (waitMode && gated[`RVM_SRC_SUPPLY_OC]) |=> wakeWait;
  endproperty
  a_supply_oc: assert property (p_supply_oc) else $error("over-current missed wait wake");

  property p_periodic;
    @(posedge core_clk) disable iff (!resetn)
    (stopMode && gated[`RVM_SRC_PERIODIC]) |=> wakeStop;
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic timer missed stop wake");

  property p_masked;
    @(posedge core_clk) disable iff (!resetn)
    (ccrIMask && !(srcFlag[`RVM_SRC_XREQ] && !ccrXMask)) |=> !coreIrq;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request reached core");

  property p_spurious;
    @(posedge core_clk) disable iff (!resetn)
    (vecFetch && !ackValid_q) |=> vectorAddr[7:0] == `RVM_OFF_SPURIOUS;
  endproperty
  a_spurious: assert property (p_spurious) else $error("spurious vector not given");

  c_xreq_vector: cover property (@(posedge core_clk) disable iff (!resetn)
    vectorValid && vectorAddr[7:0] == 8'hF4);
  c_spurious: cover property (@(posedge core_clk) disable iff (!resetn)
    vectorValid && vectorAddr[7:0] == `RVM_OFF_SPURIOUS);
  c_clkmon: cover property (@(posedge core_clk) disable iff (!resetn)
    resetValid && resetVector == `RVM_VEC_CLKMON);
  c_wake_stop: cover property (@(posedge core_clk) disable iff (!resetn) wakeStop);

endmodule : rvm_vector_ctrl

`default_nettype wire

// File: design/rvm_map.svh
// register offsets, reset values, vector figures and wake tables of the vector map
`ifndef RVM_MAP_SVH
`define RVM_MAP_SVH

// register word offsets, decoded from address bits 4:2
`define RVM_OFF_VBASE      3'h0
`define RVM_OFF_CTRL       3'h1
`define RVM_OFF_ENABLE     3'h2
`define RVM_OFF_STATUS     3'h3
`define RVM_OFF_MASK       3'h4
`define RVM_OFF_PEND       3'h5
`define RVM_OFF_VECTORS    3'h6

// control register fields
`define RVM_CTRL_OSC_EN    0
`define RVM_CTRL_WD_LSB    1
`define RVM_CTRL_WD_MSB    3
`define RVM_CTRL_BATLO_EN  4

// status and mask fields
`define RVM_ST_RESET       0
`define RVM_ST_SPURIOUS    1
`define RVM_ST_WAKE        2

// reset values
`define RVM_RST_VBASE      8'hFF
`define RVM_RST_CTRL       5'h00
`define RVM_RST_ENABLE     27'h0000000
`define RVM_RST_STATUS     3'h0
`define RVM_RST_MASK       3'h0

// vector figures
`define RVM_VEC_TOP        16'hFFFE
`define RVM_VEC_CLKMON     16'hFFFC
`define RVM_VEC_WDOG       16'hFFFA
`define RVM_OFF_SPURIOUS   8'h80

// source count and special source positions
`define RVM_NSRC           28
`define RVM_SRC_XREQ       27
`define RVM_SRC_BATT       7
`define RVM_SRC_SUPPLY_OC  5
`define RVM_SRC_PERIODIC   3

// sources allowed to end stop and wait
`define RVM_STOP_WAKE      28'hC06814D
`define RVM_WAIT_WAKE      28'hFFFEFFF

`endif

// File: design/rvm_pkg.sv
// types and shared functions of the reset and interrupt vector map
`include "rvm_map.svh"

package rvm_pkg;

  typedef logic [4:0]  rvm_idx_type;
  typedef logic [15:0] rvm_vec_type;

  typedef enum logic [0:0] {
    FETCH_IDLE  = 1'b0,
    FETCH_ACKED = 1'b1
  } rvm_fetch_type;

  // fixed offset below the vector base for each source, lowest priority first
  function automatic logic [7:0] srcOffset(input rvm_idx_type idx);
    logic [7:0] off;
    off = `RVM_OFF_SPURIOUS;
    unique case (idx)
      5'd0:  off = 8'h82;
      5'd1:  off = 8'h84;
      5'd2:  off = 8'h86;
      5'd3:  off = 8'h88;
      5'd4:  off = 8'h8A;
      5'd5:  off = 8'h8C;
      5'd6:  off = 8'h8E;
      5'd7:  off = 8'hA8;
      5'd8:  off = 8'hAA;
      5'd9:  off = 8'hAC;
      5'd10: off = 8'hAE;
      5'd11: off = 8'hB8;
      5'd12: off = 8'hBA;
      5'd13: off = 8'hC6;
      5'd14: off = 8'hC8;
      5'd15: off = 8'hCE;
      5'd16: off = 8'hD2;
      5'd17: off = 8'hD4;
      5'd18: off = 8'hD6;
      5'd19: off = 8'hD8;
      5'd20: off = 8'hDE;
      5'd21: off = 8'hE8;
      5'd22: off = 8'hEA;
      5'd23: off = 8'hEC;
      5'd24: off = 8'hEE;
      5'd25: off = 8'hF0;
      5'd26: off = 8'hF2;
      5'd27: off = 8'hF4;
      default: off = `RVM_OFF_SPURIOUS;
    endcase
    return off;
  endfunction : srcOffset

  // merge a bus write into a register word under the byte enables
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

endpackage : rvm_pkg

// File: design/rvm_prio_enc.sv
// fixed priority pick of the highest pending interrupt source
`timescale 1ns/1ps
`default_nettype none

module rvm_prio_enc
  import rvm_pkg::*;
(
  // request vector, bit 0 lowest priority
  input  wire logic [`RVM_NSRC-1:0] req,
  // winner
  output logic                      found,
  output rvm_idx_type               winIdx
);

  // higher index holds the higher vector offset and so wins
  always_comb begin
    found  = 1'b0;
    winIdx = 5'd0;
    for (int i = 0; i < `RVM_NSRC; i++) begin
      if (req[i]) begin
        found  = 1'b1;
        winIdx = i[4:0];
      end
    end
  end

endmodule : rvm_prio_enc

`default_nettype wire

// File: design/rvm_reset_sel.sv
// selection of the reset vector from the active reset causes
`timescale 1ns/1ps
`default_nettype none

module rvm_reset_sel
  import rvm_pkg::*;
(
  // causes
  input  wire logic       porReset,
  input  wire logic       lowSupplyReset,
  input  wire logic       pinReset,
  input  wire logic       illegalAddrReset,
  input  wire logic       clkMonFail,
  input  wire logic       watchdogTimeout,
  // arming controls
  input  wire logic       oscEnable,
  input  wire logic [2:0] watchdogRate,
  // result
  output logic            active,
  output rvm_vec_type     vector
);

  logic topCause;
  logic clkCause;
  logic wdCause;

  always_comb begin
    topCause = porReset | lowSupplyReset | pinReset | illegalAddrReset;
    clkCause = clkMonFail & oscEnable;
    wdCause  = watchdogTimeout & (watchdogRate != 3'h0);
    active   = topCause | clkCause | wdCause;
    if (topCause) begin
      vector = `RVM_VEC_TOP;
    end else if (clkCause) begin
      vector = `RVM_VEC_CLKMON;
    end else if (wdCause) begin
      vector = `RVM_VEC_WDOG;
    end else begin
      vector = `RVM_VEC_TOP;
    end
  end

endmodule : rvm_reset_sel

`default_nettype wire

// File: dv/rvm_core_model.sv
// processor core model: interrupt acknowledge followed by a vector fetch
`timescale 1ns/1ps
`default_nettype none

module rvm_core_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // bench command
  input  wire logic        go,
  input  wire logic        doAck,
  input  wire logic [3:0]  gap,
  output logic             done,
  output logic [15:0]      gotVec,
  // device link
  input  wire logic        vectorValid,
  input  wire logic [15:0] vectorAddr,
  output logic             intAck,
  output logic             vecFetch
);
  logic [15:0] lastVec;

  initial begin
    intAck   = 1'b0;
    vecFetch = 1'b0;
    done     = 1'b1;
    gotVec   = 16'h0000;
  end

  // one sequence per command; a missing answer leaves zero, which never matches
  always begin : seq
    @(posedge core_clk);
    if (go === 1'b1 && resetn === 1'b1) begin
      done    <= 1'b0;
      lastVec = 16'h0000;
      if (doAck) begin
        intAck <= 1'b1;
        @(posedge core_clk);
        intAck <= 1'b0;
      end
      repeat (gap) @(posedge core_clk);
      vecFetch <= 1'b1;
      @(posedge core_clk);
      vecFetch <= 1'b0;
      repeat (4) begin
        @(negedge core_clk);
        if (vectorValid === 1'b1) lastVec = vectorAddr;
      end
      @(posedge core_clk);
      gotVec <= lastVec;
      done   <= 1'b1;
    end
  end

endmodule : rvm_core_model

`default_nettype wire

// File: dv/test_rvm_vector_ctrl.sv
// self-checking bench of the vector map against a behavioural model
`timescale 1ns/1ps
`default_nettype none

module test_rvm_vector_ctrl;
  localparam logic [7:0] OFFS [28] = '{8'h82, 8'h84, 8'h86, 8'h88, 8'h8A, 8'h8C, 8'h8E,
    8'hA8, 8'hAA, 8'hAC, 8'hAE, 8'hB8, 8'hBA, 8'hC6, 8'hC8, 8'hCE, 8'hD2, 8'hD4, 8'hD6,
    8'hD8, 8'hDE, 8'hE8, 8'hEA, 8'hEC, 8'hEE, 8'hF0, 8'hF2, 8'hF4};
  localparam logic [27:0] STOPW = 28'hC06814D;
  localparam logic [27:0] WAITW = 28'hFFFEFFF;
  localparam logic [31:0] RSTV [8] = '{32'hFF, 0, 0, 0, 0, 0, 32'hFFFE0000, 0};
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h0;
  logic [27:0] srcFlag = 28'h0;
  logic        battLowFlag = 1'b0;
  logic [5:0]  cau = 6'h00;
  logic        ccrIMask = 1'b0;
  logic        ccrXMask = 1'b0;
  logic        stopMode = 1'b0;
  logic        waitMode = 1'b0;
  logic        go = 1'b0;
  logic        doAck = 1'b0;
  logic [3:0]  gap = 4'h0;
  wire  [31:0] readdata;
  wire  [15:0] vectorAddr, resetVector, gotVec;
  wire         waitrequest, coreIrq, vectorValid, resetValid, wakeStop, wakeWait, irqOut;
  wire         intAck, vecFetch, done;
  logic [31:0] q;
  logic [7:0]  vb;
  logic [4:0]  ctrl;
  logic [26:0] en;
  logic [27:0] g;
  logic        exv;
  logic [15:0] exvec;
  int          n_fail = 0;
  int          check_count = 0;
  int          seed = 4992;

  always #2.5 core_clk = ~core_clk;

  rvm_vector_ctrl i_rvm_vector_ctrl (.core_clk(core_clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .srcFlag(srcFlag), .battLowFlag(battLowFlag), .porReset(cau[0]),
    .lowSupplyReset(cau[1]), .pinReset(cau[2]), .illegalAddrReset(cau[3]),
    .clkMonFail(cau[4]), .watchdogTimeout(cau[5]), .ccrIMask(ccrIMask),
    .ccrXMask(ccrXMask), .stopMode(stopMode), .waitMode(waitMode), .intAck(intAck),
    .vecFetch(vecFetch), .coreIrq(coreIrq), .vectorAddr(vectorAddr),
    .vectorValid(vectorValid), .resetVector(resetVector), .resetValid(resetValid),
    .wakeStop(wakeStop), .wakeWait(wakeWait), .irqOut(irqOut));

  rvm_core_model i_rvm_core_model (.core_clk(core_clk), .resetn(resetn), .go(go),
    .doAck(doAck), .gap(gap), .done(done), .gotVec(gotVec), .vectorValid(vectorValid),
    .vectorAddr(vectorAddr), .intAck(intAck), .vecFetch(vecFetch));

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tmo;
    chk(32'h0, 32'h1, "wait limit");
    test_done();
  endtask : tmo

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    n = 0;
    // values read just after the edge are those the design sampled there
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) tmo();
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, exp, m);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  // drop withdraws the request just after the acknowledge is taken
  task automatic fetch(input logic ack, input logic [3:0] gp, input logic drop);
    int n;
    @(posedge core_clk);
    go <= 1'b1;
    doAck <= ack;
    gap <= gp;
    @(posedge core_clk);
    go <= 1'b0;
    if (drop) begin
      @(posedge core_clk);
      srcFlag <= 28'h0;
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 60);
    if (n >= 60) tmo();
  endtask : fetch

  function automatic logic [27:0] gated();
    logic [27:0] r;
    r = srcFlag & {1'b0, en};
    r[7] = r[7] | (battLowFlag & ctrl[4]);
    if (ccrIMask) r[26:0] = 27'h0;
    r[27] = srcFlag[27] & !ccrXMask;
    return r;
  endfunction : gated

  task automatic trial(input logic [3:0] gp);
    int w;
    settle();
    g = gated();
    w = -1;
    for (int i = 0; i < 28; i++) if (g[i]) w = i;
    chk(coreIrq, |g, "irq");
    chk(wakeStop, stopMode & |(g & STOPW), "stop wake");
    chk(wakeWait, waitMode & |(g & WAITW), "wait wake");
    rd(5'h14, {4'h0, g}, "pending");
    if (w >= 0) begin
      fetch(1'b1, gp, 1'b0);
      chk(gotVec, {vb, OFFS[w]}, "vector");
    end
  endtask : trial

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 8; k++) rd(5'(k * 4), RSTV[k], "reset value");
    bus(1'b1, 5'h1C, 32'($random(seed)), 4'hF);
    rd(5'h1C, 32'h0, "unmapped");
    vb = 8'($random(seed));
    bus(1'b1, 5'h00, {24'hA5A5A5, vb}, 4'h0);
    rd(5'h00, 32'hFF, "no lanes");
    for (int t = 0; t < 40; t++) begin
      vb = 8'($random(seed));
      en = 27'($random(seed));
      ctrl = 5'($random(seed));
      bus(1'b1, 5'h00, {24'h0, vb}, 4'h1);
      bus(1'b1, 5'h08, {5'h0, en}, 4'hF);
      bus(1'b1, 5'h04, {27'h0, ctrl}, 4'hF);
      rd(5'h08, {5'h0, en}, "enables");
      rd(5'h04, {27'h0, ctrl}, "control");
      srcFlag <= 28'($random(seed)) & 28'($random(seed));
      battLowFlag <= 1'($random(seed));
      ccrIMask <= (($random(seed) & 3) == 0);
      ccrXMask <= (($random(seed) & 3) == 0);
      stopMode <= 1'($random(seed));
      waitMode <= 1'($random(seed));
      trial(4'(t % 4));
    end
    en = 27'h7FFFFFF;
    bus(1'b1, 5'h08, {5'h0, en}, 4'hF);
    ccrIMask <= 1'b0;
    ccrXMask <= 1'b0;
    battLowFlag <= 1'b0;
    stopMode <= 1'b1;
    waitMode <= 1'b1;
    for (int i = 0; i < 28; i++) begin
      srcFlag <= 28'h1 << i;
      trial(4'h0);
    end
    stopMode <= 1'b0;
    waitMode <= 1'b0;
    bus(1'b1, 5'h0C, 32'h7, 4'hF);
    bus(1'b1, 5'h10, 32'h2, 4'hF);
    srcFlag <= 28'h8;
    fetch(1'b1, 4'h6, 1'b1);
    chk(gotVec, {vb, 8'h80}, "withdrawn");
    rd(5'h0C, 32'h2, "spurious flag");
    settle();
    chk(irqOut, 1'b1, "summary set");
    bus(1'b1, 5'h0C, 32'h2, 4'hF);
    rd(5'h0C, 32'h0, "status clear");
    settle();
    chk(irqOut, 1'b0, "summary clear");
    srcFlag <= 28'h8;
    fetch(1'b0, 4'h0, 1'b0);
    chk(gotVec, {vb, 8'h80}, "no ack");
    for (int k = 0; k < 24; k++) begin
      ctrl[0] = (k < 6) ? 1'b0 : (k < 12) ? 1'b1 : 1'($random(seed));
      ctrl[3:1] = (k < 6) ? 3'h0 : (k < 12) ? 3'(1 + k % 7) : 3'($random(seed));
      ctrl[4] = 1'b0;
      bus(1'b1, 5'h04, {27'h0, ctrl}, 4'hF);
      cau <= (k < 12) ? 6'(1 << (k % 6)) : 6'($random(seed)) & 6'($random(seed));
      settle();
      exv = |cau[3:0] | (cau[4] & ctrl[0]) | (cau[5] & |ctrl[3:1]);
      exvec = |cau[3:0] ? 16'hFFFE : (cau[4] & ctrl[0]) ? 16'hFFFC : 16'hFFFA;
      chk(resetValid, exv, "reset valid");
      if (exv) chk(resetVector, exvec, "reset vector");
      @(posedge core_clk);
      cau <= 6'h00;
    end
    rd(5'h0C, 32'h3, "reset seen");
    test_done();
  end

endmodule : test_rvm_vector_ctrl

`default_nettype wire
